// ==== rtl/bbt_blit_ctrl.v ====
/*
 * Control, masking, shifting, logic-function and fill datapath of a bit-block transfer engine,
 * with area and line modes, an APB register slave and a two-entry destination write buffer.
 * Assumes a memory read port that answers each request with one rd_ack pulse, and a write
 * sink that accepts a word whenever wr_valid and wr_ready are both high at a rising edge.
 */
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "bbt_map.vh"

// How it works
// - Source A's first word of a line, when read from memory, is ANDed with the first mask, last with last.
// - A zero mask bit clears that bit of source A data read from memory; a source A word written over APB is used unmasked.
// - Control-second bit 0 picks area mode (0) or line mode (1).
// - Area mode: control-first bits 15..12 shift source A.
// - Area mode: control-second bits 15..12 shift source B.
// - Control-first bits 11..8 enable sources A, B, C and destination D; line mode always reads C alone and uses only the D bit.
// - Control-first bits 7..0 are the eight minterms combining A, B, C.
// - Area mode: control-second bit 4 exclusive fill, bit 3 inclusive fill.
// - Area mode: control-second bit 2 is the fill carry at each line start.
// - Area mode: control-second bit 1 makes addresses step downward.
// - Line mode: source B data is the texture pattern along the line.
// - Writing the size register (10-bit height, 6-bit width) starts the operation.
// - Area mode: at each line end every enabled channel adds its modulo to its address, or subtracts it when descending.
module bbt_blit_ctrl #(
	parameter AW = 18
) (
	// APB slave.
	input  wire          pclk,
	input  wire          presetn,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [11:0]   paddr,
	input  wire [31:0]   pwdata,
	output wire [31:0]   prdata,
	output wire          pready,
	output wire          pslverr,
	// Memory read port.
	output wire          rd_req,
	output wire [AW-1:0] rd_addr,
	input  wire          rd_ack,
	input  wire [15:0]   rd_data,
	// Destination write stream.
	output wire          wr_valid,
	input  wire          wr_ready,
	output wire [AW-1:0] wr_addr,
	output wire [15:0]   wr_data,
	// Status.
	output wire          busy
);

	localparam S_IDLE = 3'b000;
	localparam S_RD   = 3'b001;
	localparam S_CALC = 3'b010;
	localparam S_PUSH = 3'b011;
	localparam S_STEP = 3'b100;

	reg  [15:0]   con0_q, con1_q, afwm_q, alwm_q, tex_q, res_q;
	reg  [15:0]   dat_q [0:2];
	reg  [15:0]   prv_q [0:1];
	reg  [AW-1:0] ptr_q [0:3];
	reg  [AW-1:0] mod_q [0:3];
	reg  [2:0]    state_q;
	reg  [1:0]    ch_q;
	reg  [10:0]   lines_q;
	reg  [6:0]    width_q, words_q;
	reg           carry_q, sign_q, drew_q, push_q;
	reg  [3:0]    pos_q;
	reg  [31:0]   prdata_q;
	reg           err_q;
	reg  [AW-1:0] buf_a_q [0:1];
	reg  [15:0]   buf_d_q [0:1];
	reg           bw_q, br_q;
	reg  [1:0]    cnt_q;
	integer       i;

	wire [9:0] idx      = paddr[11:2];
	wire       setup    = psel & ~penable;
	wire       wr_acc   = psel & penable & pwrite;
	wire       line_m   = con1_q[`BBT_LINE];
	wire [3:0] source_a_shift      = con0_q[`BBT_SH_HI:`BBT_SH_LO];
	wire [3:0] source_b_shift      = con1_q[`BBT_SH_HI:`BBT_SH_LO];
	wire [3:0] use_abcd = con0_q[`BBT_ENABLE_SOURCE_A:`BBT_USED];
	wire [7:0] lf       = con0_q[`BBT_LF_HI:`BBT_LF_LO];
	wire       descending_addr     = ~line_m & con1_q[`BBT_DESCENDING_ADDR];
	wire       first_w  = (words_q == width_q);
	wire       last_w   = (words_q == 7'd1);
	wire [2:0] src_en   = line_m ? 3'b100 : {use_abcd[1], use_abcd[2], use_abcd[3]};
	wire       buf_in_rdy = (cnt_q != 2'd2);
	wire       buf_push   = (state_q == S_PUSH) & push_q & buf_in_rdy;
	wire       buf_pop    = wr_valid & wr_ready;

	// Picks the lowest enabled source channel at or after a start index; bit 2 flags a hit.
	function [2:0] pick;
		input [2:0] en;
		input [1:0] from;
		integer k;
		begin
			pick = 3'b000;
			for (k = 2; k >= 0; k = k - 1) begin
				if (en[k] && (k >= from))
					pick = {1'b1, k[1:0]};
			end
		end
	endfunction

	// Barrel shift across the previous and current word of one stream.
	function [15:0] shf;
		input [15:0] cur;
		input [15:0] prv;
		input [3:0]  sh;
		input        dn;
		reg   [31:0] t;
		begin
			t = dn ? ({cur, prv} << sh) : ({prv, cur} >> sh);
			shf = dn ? t[31:16] : t[15:0];
		end
	endfunction

	// Per bit, the minterm indexed by {a,b,c} gives the destination bit.
	function [15:0] minterm;
		input [7:0]  sel;
		input [15:0] a;
		input [15:0] b;
		input [15:0] c;
		integer k;
		begin
			minterm = `BBT_RST16;
			for (k = 0; k < 16; k = k + 1)
				minterm[k] = sel[{a[k], b[k], c[k]}];
		end
	endfunction

	// Fill from bit 0 upward; returns {carry out, filled word}.
	function [16:0] fill;
		input [15:0] d;
		input        cin;
		input        excl;
		reg          c;
		integer      k;
		begin
			c = cin;
			fill = 17'h00000;
			for (k = 0; k < 16; k = k + 1) begin
				if (excl) begin
					c = c ^ d[k];
					fill[k] = c;
				end else begin
					fill[k] = c | d[k];
					c = c ^ d[k];
				end
			end
			fill[16] = c;
		end
	endfunction

	wire [2:0] nxt_rd   = pick(src_en, ch_q + 2'd1);
	wire [2:0] first_rd = pick(src_en, 2'd0);
	wire [15:0] a_mask  = (first_w ? afwm_q : `BBT_ONES16) & (last_w ? alwm_q : `BBT_ONES16);
	wire        fill_on = con1_q[`BBT_EFE] | con1_q[`BBT_IFE];
	wire [15:0] area_m  = minterm(lf, shf(dat_q[0], prv_q[0], source_a_shift, descending_addr), shf(dat_q[1], prv_q[1], source_b_shift, descending_addr), dat_q[2]);
	wire [16:0] area_f  = fill(area_m, carry_q, con1_q[`BBT_EFE]);
	wire [15:0] line_r  = minterm(lf, `BBT_DOT_MSB >> pos_q, {16{tex_q[15]}}, dat_q[2]);

	// Line stepping: the octant bits choose the major axis and both directions.
	wire          maj_h  = con1_q[`BBT_SUD];
	wire          maj_n  = con1_q[`BBT_AUL];
	wire          min_n  = con1_q[`BBT_SUL];
	wire          do_min = ~sign_q;
	wire          mv_h   = maj_h | do_min;
	wire          mv_v   = ~maj_h | do_min;
	wire          h_neg  = maj_h ? maj_n : min_n;
	wire          v_neg  = maj_h ? min_n : maj_n;
	wire [AW-1:0] acc_n  = ptr_q[0] + (do_min ? mod_q[0] : mod_q[1]);
	wire [3:0]    pos_n  = h_neg ? pos_q - 4'd1 : pos_q + 4'd1;
	wire          wrap   = h_neg ? (pos_q == 4'd0) : (pos_q == 4'hF);
	wire [AW-1:0] h_ofs  = (mv_h & wrap) ? (h_neg ? -`BBT_WORD_STEP : `BBT_WORD_STEP) : `BBT_RST18;
	wire [AW-1:0] v_ofs  = mv_v ? (v_neg ? -mod_q[2] : mod_q[2]) : `BBT_RST18;

	////////////////////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data loaded in the setup cycle.
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = err_q & psel & penable;

	function mapped;
		input [9:0] a;
		begin
			mapped = (a == `BBT_IDX_CON0) || (a == `BBT_IDX_CON1) || (a == `BBT_IDX_AFWM) ||
				(a == `BBT_IDX_ALWM) || (a == `BBT_IDX_SIZE) || (a == `BBT_IDX_ADAT) ||
				(a == `BBT_IDX_BDAT) || (a == `BBT_IDX_STAT) ||
				((a & `BBT_IDX_CH_MASK) == `BBT_IDX_PTR0) || ((a & `BBT_IDX_CH_MASK) == `BBT_IDX_MOD0);
		end
	endfunction

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			err_q    <= 1'b0;
		end else if (setup) begin
			err_q    <= ~mapped(idx);
			prdata_q <= 32'h00000000;
			if (idx == `BBT_IDX_STAT)
				prdata_q <= {31'h00000000, busy};
			else if ((idx & `BBT_IDX_CH_MASK) == `BBT_IDX_PTR0)
				prdata_q <= {{(32-AW){1'b0}}, ptr_q[idx[1:0]]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Control registers, pointers and the transfer sequencer.
	assign busy    = (state_q != S_IDLE);
	assign rd_req  = (state_q == S_RD);
	assign rd_addr = ptr_q[ch_q];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			con0_q  <= `BBT_RST16;
			con1_q  <= `BBT_RST16;
			afwm_q  <= `BBT_RST16;
			alwm_q  <= `BBT_RST16;
			tex_q   <= `BBT_RST16;
			res_q   <= `BBT_RST16;
			state_q <= S_IDLE;
			ch_q    <= 2'd0;
			lines_q <= 11'd0;
			width_q <= 7'd0;
			words_q <= 7'd0;
			carry_q <= 1'b0;
			sign_q  <= 1'b0;
			drew_q  <= 1'b0;
			push_q  <= 1'b0;
			pos_q   <= 4'd0;
			for (i = 0; i < 4; i = i + 1) begin
				ptr_q[i] <= `BBT_RST18;
				mod_q[i] <= `BBT_RST18;
			end
			for (i = 0; i < 3; i = i + 1)
				dat_q[i] <= `BBT_RST16;
			for (i = 0; i < 2; i = i + 1)
				prv_q[i] <= `BBT_RST16;
		end else begin
			if (wr_acc && !busy) begin
				case (idx)
					`BBT_IDX_CON0: con0_q   <= pwdata[15:0];
					`BBT_IDX_CON1: con1_q   <= pwdata[15:0];
					`BBT_IDX_AFWM: afwm_q   <= pwdata[15:0];
					`BBT_IDX_ALWM: alwm_q   <= pwdata[15:0];
					`BBT_IDX_ADAT: dat_q[0] <= pwdata[15:0];
					`BBT_IDX_BDAT: dat_q[1] <= pwdata[15:0];
					default: begin
						if ((idx & `BBT_IDX_CH_MASK) == `BBT_IDX_PTR0)
							ptr_q[idx[1:0]] <= pwdata[AW-1:0];
						if ((idx & `BBT_IDX_CH_MASK) == `BBT_IDX_MOD0)
							mod_q[idx[1:0]] <= pwdata[AW-1:0];
					end
				endcase
			end
			case (state_q)
				S_IDLE: begin
					if (wr_acc && idx == `BBT_IDX_SIZE) begin
						lines_q <= (pwdata[`BBT_H_HI:`BBT_H_LO] == 10'd0) ? 11'h400 :
							{1'b0, pwdata[`BBT_H_HI:`BBT_H_LO]};
						width_q <= (pwdata[`BBT_W_HI:`BBT_W_LO] == 6'd0) ? 7'h40 :
							{1'b0, pwdata[`BBT_W_HI:`BBT_W_LO]};
						words_q <= (pwdata[`BBT_W_HI:`BBT_W_LO] == 6'd0) ? 7'h40 :
							{1'b0, pwdata[`BBT_W_HI:`BBT_W_LO]};
						carry_q <= con1_q[`BBT_FCI];
						sign_q  <= con1_q[`BBT_SIGN];
						pos_q   <= con0_q[`BBT_SH_HI:`BBT_SH_LO];
						tex_q   <= dat_q[1];
						drew_q  <= 1'b0;
						prv_q[0] <= `BBT_RST16;
						prv_q[1] <= `BBT_RST16;
						ch_q    <= first_rd[1:0];
						state_q <= first_rd[2] ? S_RD : S_CALC;
					end
				end
				S_RD: begin
					if (rd_ack) begin
						if (ch_q == 2'd0) begin
							dat_q[0] <= rd_data & a_mask;
							prv_q[0] <= dat_q[0];
						end else if (ch_q == 2'd1) begin
							dat_q[1] <= rd_data;
							prv_q[1] <= dat_q[1];
						end else
							dat_q[2] <= rd_data;
						ch_q    <= nxt_rd[1:0];
						state_q <= nxt_rd[2] ? S_RD : S_CALC;
					end
				end
				S_CALC: begin
					if (line_m) begin
						res_q  <= line_r;
						push_q <= use_abcd[0] & ~(con1_q[`BBT_SING] & drew_q);
						drew_q <= 1'b1;
					end else begin
						res_q   <= fill_on ? area_f[15:0] : area_m;
						carry_q <= area_f[16];
						push_q  <= use_abcd[0];
					end
					state_q <= S_PUSH;
				end
				S_PUSH: begin
					if (buf_in_rdy || !push_q)
						state_q <= S_STEP;
				end
				S_STEP: begin
					if (line_m) begin
						ptr_q[0] <= acc_n;
						sign_q   <= acc_n[AW-1];
						tex_q    <= {tex_q[14:0], tex_q[15]};
						if (mv_h)
							pos_q <= pos_n;
						if (mv_v)
							drew_q <= 1'b0;
						ptr_q[2] <= ptr_q[2] + h_ofs + v_ofs;
						ptr_q[3] <= ptr_q[3] + h_ofs + v_ofs;
						lines_q  <= lines_q - 11'd1;
					end else begin
						for (i = 0; i < 4; i = i + 1) begin
							if (use_abcd[3-i]) begin
								if (descending_addr)
									ptr_q[i] <= ptr_q[i] - `BBT_WORD_STEP - (last_w ? mod_q[i] : `BBT_RST18);
								else
									ptr_q[i] <= ptr_q[i] + `BBT_WORD_STEP + (last_w ? mod_q[i] : `BBT_RST18);
							end
						end
						if (last_w) begin
							words_q  <= width_q;
							lines_q  <= lines_q - 11'd1;
							carry_q  <= con1_q[`BBT_FCI];
							prv_q[0] <= `BBT_RST16;
							prv_q[1] <= `BBT_RST16;
						end else
							words_q <= words_q - 7'd1;
					end
					ch_q <= first_rd[1:0];
					if ((line_m || last_w) && lines_q == 11'd1)
						state_q <= S_IDLE;
					else
						state_q <= first_rd[2] ? S_RD : S_CALC;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Two-entry destination buffer; once both entries are full, a stalled sink holds the sequencer in S_PUSH.
	assign wr_valid = (cnt_q != 2'd0);
	assign wr_addr  = buf_a_q[br_q];
	assign wr_data  = buf_d_q[br_q];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bw_q  <= 1'b0;
			br_q  <= 1'b0;
			cnt_q <= 2'd0;
			for (i = 0; i < 2; i = i + 1) begin
				buf_a_q[i] <= `BBT_RST18;
				buf_d_q[i] <= `BBT_RST16;
			end
		end else begin
			if (buf_push) begin
				buf_a_q[bw_q] <= ptr_q[3];
				buf_d_q[bw_q] <= res_q;
				bw_q          <= ~bw_q;
			end
			if (buf_pop)
				br_q <= ~br_q;
			if (buf_push && !buf_pop)
				cnt_q <= cnt_q + 2'd1;
			else if (buf_pop && !buf_push)
				cnt_q <= cnt_q - 2'd1;
		end
	end

endmodule // bbt_blit_ctrl

// ==== rtl/bbt_map.vh ====
/*
 * Register indices, field positions and constants of the bit-block transfer control block.
 * Assumes a 32-bit APB slave where each register index sits at byte address index times four.
 */
`ifndef BBT_MAP_VH
`define BBT_MAP_VH

// Register indices (byte address is index times four).
`define BBT_IDX_CON0     10'h040
`define BBT_IDX_CON1     10'h042
`define BBT_IDX_AFWM     10'h044
`define BBT_IDX_ALWM     10'h046
`define BBT_IDX_SIZE     10'h058
`define BBT_IDX_ADAT     10'h074
`define BBT_IDX_BDAT     10'h076
`define BBT_IDX_STAT     10'h07E
`define BBT_IDX_PTR0     10'h080
`define BBT_IDX_MOD0     10'h084
`define BBT_IDX_CH_MASK  10'h3FC

// Field positions of both control registers.
`define BBT_SH_HI        15
`define BBT_SH_LO        12
`define BBT_ENABLE_SOURCE_A         11
`define BBT_ENABLE_SOURCE_B         10
`define BBT_ENABLE_SOURCE_C         9
`define BBT_USED         8
`define BBT_LF_HI        7
`define BBT_LF_LO        0
`define BBT_EFE          4
`define BBT_IFE          3
`define BBT_FCI          2
`define BBT_DESCENDING_ADDR         1
`define BBT_LINE         0
`define BBT_SIGN         6
`define BBT_SUD          4
`define BBT_SUL          3
`define BBT_AUL          2
`define BBT_SING         1

// Size register fields.
`define BBT_H_HI         15
`define BBT_H_LO         6
`define BBT_W_HI         5
`define BBT_W_LO         0

// Reset values and steps.
`define BBT_RST16        16'h0000
`define BBT_RST18        18'h00000
`define BBT_ONES16       16'hFFFF
`define BBT_WORD_STEP    18'h00002
`define BBT_DOT_MSB      16'h8000

`endif

// ==== bench/bbt_mem_model.sv ====
/* Memory model on the far side of the blit engine: answers reads after 0..3 waits, stalls writes.
 * Assumes one rd_ack pulse per request and a word accepted when wr_valid and wr_ready meet. */
`timescale 1ns/10ps
module bbt_mem_model #(
	parameter AW = 18
) (
	// Read port.
	input  wire          pclk,
	input  wire          presetn,
	input  wire          rd_req,
	input  wire [AW-1:0] rd_addr,
	output reg           rd_ack,
	output reg  [15:0]   rd_data,
	// Write sink.
	output reg           wr_ready
);
	integer   seed;
	reg [1:0] wait_q;
	initial seed = 32'h23F4FFB8;
	function [15:0] word_at(input [AW-1:0] a);
		word_at = a[16:1] * 16'h9E37 ^ 16'h3C5A;
	endfunction
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ack   <= 1'b0;
			rd_data  <= 16'h0000;
			wait_q   <= 2'h0;
			wr_ready <= 1'b0;
		end else begin
			// Ready on a random one cycle in four on average, so the two-entry buffer fills up.
			wr_ready <= ($random(seed) & 3) == 0;
			rd_ack   <= 1'b0;
			// Data toggles while idle so a stale word never passes for an answer.
			rd_data  <= ~rd_data;
			if (rd_req && !rd_ack) begin
				if (wait_q == 2'h0) begin
					rd_ack  <= 1'b1;
					rd_data <= word_at(rd_addr);
					wait_q  <= $random(seed);
				end else begin
					wait_q <= wait_q - 2'h1;
				end
			end
		end
	end
endmodule // bbt_mem_model

// ==== bench/bbt_blit_chk.sv ====
/* Port checker for the blit control block.
 * Assumes the register map header; bound to every instance of the block. */
`timescale 1ns/10ps
`include "bbt_map.vh"
module bbt_blit_chk #(
	parameter AW = 18
) (
	input wire          pclk,
	input wire          presetn,
	input wire          psel,
	input wire          penable,
	input wire          pwrite,
	input wire [11:0]   paddr,
	input wire [31:0]   prdata,
	input wire          pready,
	input wire          pslverr,
	input wire          rd_req,
	input wire [AW-1:0] rd_addr,
	input wire          rd_ack,
	input wire          wr_valid,
	input wire          wr_ready,
	input wire [AW-1:0] wr_addr,
	input wire [15:0]   wr_data,
	input wire          busy
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire [9:0] idx = paddr[11:2];
	wire       rd_setup = psel && !penable && !pwrite;
	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_err_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	chk_err_unmap: assert property (psel && !penable && idx == 10'h3FF |=> pslverr)
		else $error("unmapped access not flagged");
	chk_rd_hold: assert property (rd_req && !rd_ack |=> rd_req && $stable(rd_addr))
		else $error("read request changed before ack");
	chk_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data) && $stable(wr_addr))
		else $error("write word changed before taken");
	chk_size_start: assert property (psel && penable && pwrite && idx == `BBT_IDX_SIZE && !busy |=> busy)
		else $error("size write did not start");
	chk_idle_quiet: assert property (!busy |-> !rd_req)
		else $error("read while idle");
	chk_stat_busy: assert property (rd_setup && idx == `BBT_IDX_STAT |=> prdata[0] == $past(busy))
		else $error("status bit differs from busy");
	chk_wo_zero: assert property (rd_setup && idx == `BBT_IDX_CON0 |=> prdata == 32'h00000000)
		else $error("write-only register read not zero");
	cov_start: cover property (psel && penable && pwrite && idx == `BBT_IDX_SIZE);
	cov_stall: cover property (wr_valid && !wr_ready ##1 wr_valid && wr_ready);
	cov_err: cover property (pslverr);
endmodule // bbt_blit_chk
bind bbt_blit_ctrl bbt_blit_chk #(.AW(AW)) bbt_blit_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .wr_valid(wr_valid), .wr_ready(wr_ready),
	.wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));

// ==== bench/tb_top.sv ====
/* Self-checking bench: register access, masked, descending and random area blits.
 * Assumes the register map header and the memory model as far side. */
`timescale 1ns/10ps
`include "bbt_map.vh"
module tb_top;
	reg           pclk;
	reg           presetn;
	reg           psel;
	reg           penable;
	reg           pwrite;
	reg  [11:0]   paddr;
	reg  [31:0]   pwdata;
	wire [31:0]   prdata;
	wire          pready;
	wire          pslverr;
	wire          rd_req;
	wire [17:0]   rd_addr;
	wire          rd_ack;
	wire [15:0]   rd_data;
	wire          wr_valid;
	wire          wr_ready;
	wire [17:0]   wr_addr;
	wire [15:0]   wr_data;
	wire          busy;
	integer       bad_count;
	integer       checked;
	integer       seed;
	integer       k;
	reg  [31:0]   r;
	reg  [31:0]   rdat;
	reg           errf;
	reg  [15:0]   care;
	reg  [33:0]   exp_q[$];
	bbt_blit_ctrl #(.AW(18)) bbt_blit_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));
	bbt_mem_model #(.AW(18)) bbt_mem_model_inst (.pclk(pclk), .presetn(presetn), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .wr_ready(wr_ready));
	function [15:0] word_at(input [17:0] a);
		word_at = a[16:1] * 16'h9E37 ^ 16'h3C5A;
	endfunction
	task cmp(input [8*12:1] what, input [31:0] e, input [31:0] g);
		begin
			checked = checked + 1;
			if (e !== g) begin
				bad_count = bad_count + 1;
				$display("[ERR] %0s expected %h seen %h", what, e, g);
			end
		end
	endtask
	task cmp_addr(input [17:0] e, input [17:0] g);
		begin
			checked = checked + 1;
			if (e !== g) begin
				bad_count = bad_count + 1;
				$display("[ERR] wr_addr expected %h seen %h", e, g);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d errors %0d", checked, bad_count);
			if (bad_count == 0 && checked > 0) begin
				$display("Finished cleanly");
			end else begin
				$display("Finished with errors");
			end
			$finish;
		end
	endtask
	task apb(input w, input [9:0] idx, input [31:0] d);
		begin
			psel    <= 1'b1;
			pwrite  <= w;
			paddr   <= {idx, 2'b00};
			pwdata  <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			rdat = prdata;
			errf = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Sets up one blit, queues the expected words, starts it and waits for the end.
	task blit(input [15:0] c0, input [15:0] c1, input [5:0] w, input [9:0] h, input [17:0] ma, input [17:0] md,
		input [15:0] fm, input [15:0] lm);
		reg [17:0] ea, eb, ec, ed, st;
		reg [15:0] a, b, c, d;
		reg        fc, t;
		integer x, y, i;
		begin
			st = c1[1] ? 18'h3FFFE : 18'h00002;
			ea = c1[1] ? 18'h01FFE : 18'h01000;
			eb = ea + 18'h01000;
			ec = ea + 18'h02000;
			ed = ea + 18'h03000;
			care = 16'hFFFF >> (c0[15:12] > c1[15:12] ? c0[15:12] : c1[15:12]);
			apb(1'b1, `BBT_IDX_CON0, c0);
			apb(1'b1, `BBT_IDX_CON1, c1);
			apb(1'b1, `BBT_IDX_AFWM, fm);
			apb(1'b1, `BBT_IDX_ALWM, lm);
			apb(1'b1, `BBT_IDX_MOD0, ma);
			apb(1'b1, `BBT_IDX_MOD0 + 10'h003, md);
			for (i = 0; i < 4; i = i + 1) apb(1'b1, `BBT_IDX_PTR0 + i[9:0], ea + i * 4096);
			for (y = 0; y < h; y = y + 1) begin
				fc = c1[2];
				for (x = 0; x < w; x = x + 1) begin
					a = word_at(ea);
					b = word_at(eb);
					c = word_at(ec);
					if (x == 0) a = a & fm;
					if (x == w - 1) a = a & lm;
					a = a >> c0[15:12];
					b = b >> c1[15:12];
					for (i = 0; i < 16; i = i + 1) d[i] = c0[{a[i], b[i], c[i]}];
					// Fill runs from bit 0 upward and carries across the words of one line.
					for (i = 0; i < 16; i = i + 1) begin
						t = d[i];
						if (c1[4]) begin
							fc = fc ^ t;
							d[i] = fc;
						end else if (c1[3]) begin
							d[i] = fc | t;
							fc = fc ^ t;
						end
					end
					exp_q.push_back({ed, d});
					ea = ea + st;
					eb = eb + st;
					ec = ec + st;
					ed = ed + st;
				end
				ea = c1[1] ? ea - ma : ea + ma;
				ed = c1[1] ? ed - md : ed + md;
			end
			apb(1'b1, `BBT_IDX_SIZE, {h, w});
			apb(1'b0, `BBT_IDX_STAT, 32'h0);
			cmp("status busy", 32'h1, {31'h0, rdat[0]});
			while (busy !== 1'b0 || wr_valid !== 1'b0) @(posedge pclk);
			cmp("words left", 32'h0, exp_q.size());
			apb(1'b0, `BBT_IDX_PTR0 + 10'h003, 32'h0);
			cmp("end pointer", {14'h0, ed}, rdat);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Draws a one-dot solid line; the dot ORs into the word read through source C.
	task line1(input [3:0] s);
		integer j;
		begin
			care = 16'hFFFF;
			apb(1'b1, `BBT_IDX_CON0, {s, 4'hB, 8'hCA});
			apb(1'b1, `BBT_IDX_CON1, 32'h1);
			apb(1'b1, `BBT_IDX_AFWM, 32'hFFFF);
			apb(1'b1, `BBT_IDX_ALWM, 32'hFFFF);
			apb(1'b1, `BBT_IDX_ADAT, 32'h8000);
			apb(1'b1, `BBT_IDX_BDAT, 32'hFFFF);
			for (j = 0; j < 4; j = j + 1) begin
				apb(1'b1, `BBT_IDX_PTR0 + j[9:0], 32'h3000);
				apb(1'b1, `BBT_IDX_MOD0 + j[9:0], 32'h0);
			end
			exp_q.push_back({18'h03000, word_at(18'h03000) | (16'h8000 >> s)});
			apb(1'b1, `BBT_IDX_SIZE, {16'h0, 10'h001, 6'h02});
			while (busy !== 1'b0 || wr_valid !== 1'b0) @(posedge pclk);
			cmp("line words", 32'h0, exp_q.size());
		end
	endtask
	always @(posedge pclk) begin
		if (presetn && wr_valid === 1'b1 && wr_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				cmp("spare write", 32'h1, 32'h0);
			end else begin
				cmp_addr(exp_q[0][33:16], wr_addr);
				cmp("dest word", {16'h0, exp_q[0][15:0] & care}, {16'h0, wr_data & care});
				void'(exp_q.pop_front());
			end
		end
	end
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		#3000000;
		bad_count = bad_count + 1;
		report_and_stop;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		bad_count = 0;
		checked = 0;
		seed = 32'h23F4FFB8;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `BBT_IDX_CON0, 32'h0);
		cmp("wo read", 32'h0, rdat);
		apb(1'b0, 10'h3FF, 32'h0);
		cmp("unmapped err", 32'h1, {31'h0, errf});
		blit(16'h09F0, 16'h0000, 6'h03, 10'h002, 18'h00006, 18'h0000A, 16'hF0F1, 16'h8FFF);
		blit(16'h09F0, 16'h0002, 6'h02, 10'h003, 18'h00004, 18'h00008, 16'h7FFE, 16'hFF0F);
		blit(16'h09F0, 16'h0000, 6'h01, 10'h001, 18'h0, 18'h0, 16'h0FF0, 16'hF00F);
		blit(16'h09F0, 16'h0014, 6'h02, 10'h002, 18'h0, 18'h0, 16'hFFFF, 16'hFFFF);
		blit(16'h09F0, 16'h0008, 6'h02, 10'h002, 18'h0, 18'h0, 16'hFFFF, 16'hFFFF);
		line1(4'h0);
		line1(4'h9);
		for (k = 0; k < 40; k = k + 1) begin
			r = $random(seed);
			blit({r[15:12], 4'hF, r[7:0]}, {r[19:16], 12'h000}, 6'h01, 10'h001, 18'h0, 18'h0, 16'hFFFF,
				16'hFFFF);
		end
		report_and_stop;
	end
endmodule // tb_top
